// >>> hw/burst_detector.sv
// device end: hunts burst preambles in the received word stream
// captures burst info and length, decodes the info fields and reports
// detection, loss of stream and unlock through apb registers and one irq.
// assumes link words arrive one per frame on a one-cycle strobe synchronous
// to pclk, and pll_unlock is a level synchronous to pclk.
//
// Contract
// - first sync word 0xf872 starts a preamble
// - second sync word 0x4e1f must follow
// - next words captured as info, length
// - info bits 0-4 decoded as data type
// - source repeats bursts per type interval
// - types 11-15, 27, 28 repeat intervals
// - info bits 5, 6 reserved zero
// - info bit 7 is the error flag
// - info bits 8-12 passed through uninterpreted
// - bitstream number bits 13-15 zero
// - 4096 frames without preamble ends stream
// - readable detect bit while stream present
// - info and length readable as bytes
// - unlock mask bit gates unlock interrupt
`include "burst_map.svh"

module burst_detector #(
  parameter int GAP_FRAMES = `GAP_FRAMES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receiver side
  input  wire logic        pll_unlock,
  output logic             detect,
  output logic             irq,
  // link
  burst_link_if.dev        link
);
  import burst_pkg::*;

  dev_state_t  s_reg;
  dev_state_t  s_next;
  logic        gap_expired;
  logic [4:0]  ev;
  logic [4:0]  w1c;
  logic        access;
  logic        commit;
  logic [31:0] rd;
  logic        rd_err;

  frame_gap_timer #(
    .GAP_FRAMES (GAP_FRAMES)
  ) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (s_reg.found),
    .frame   (link.word_valid),
    .expired (gap_expired)
  );

  function automatic logic type_reserved(input logic [4:0] t);
    case (t)
      5'h02, 5'h07, 5'h0a: type_reserved = 1'b1;
      default:             type_reserved = (t >= 5'h10 && t <= 5'h1a) || (t >= 5'h1d);
    endcase
  endfunction

  // live view of the last captured info word plus stream state
  function automatic logic [31:0] status_word(input dev_state_t s, input logic unl);
    logic [31:0] w;
    w                         = 32'h0000_0000;
    w[`ST_DETECT]             = s.detect;
    w[`ST_UNLOCK]             = unl;
    w[`ST_TYPE_LSB +: 5]      = s.info[`PC_TYPE_LSB +: 5];
    w[`ST_NULL]               = s.info[`PC_TYPE_LSB +: 5] == `TYPE_NULL;
    w[`ST_PAUSE]              = s.info[`PC_TYPE_LSB +: 5] == `TYPE_PAUSE;
    w[`ST_RSV_TYPE]           = type_reserved(s.info[`PC_TYPE_LSB +: 5]);
    w[`ST_ERR]                = s.info[`PC_ERR_BIT];
    w[`ST_RSV_BITS]           = |s.info[`PC_RSV_LSB +: 2];
    w[`ST_DEP_LSB +: 5]       = s.info[`PC_DEP_LSB +: 5];
    w[`ST_NUM_LSB +: 3]       = s.info[`PC_NUM_LSB +: 3];
    status_word = w;
  endfunction

  always_comb begin
    s_next       = s_reg;
    s_next.found = 1'b0;
    ev           = 5'h00;

    // preamble hunt, one aligned word per frame
    if (link.word_valid) begin
      case (s_reg.st)
        ST_HUNT: begin
          if (link.word == `SYNC_PA) begin
            s_next.st = ST_SYNC2;
          end
        end
        ST_SYNC2: begin
          if (link.word == `SYNC_PB) begin
            s_next.st = ST_INFO;
          end else if (link.word == `SYNC_PA) begin
            s_next.st = ST_SYNC2;
          end else begin
            s_next.st = ST_HUNT;
          end
        end
        ST_INFO: begin
          s_next.info = link.word;
          s_next.st   = ST_LEN;
        end
        ST_LEN: begin
          s_next.len    = link.word;
          s_next.st     = ST_HUNT;
          s_next.detect = 1'b1;
          s_next.found  = 1'b1;
          ev[`IRQ_FOUND] = 1'b1;
          ev[`IRQ_ERR]   = s_reg.info[`PC_ERR_BIT];
          // a burst that breaks the reserved encodings is flagged, not dropped
          ev[`IRQ_RSV]   = type_reserved(s_reg.info[`PC_TYPE_LSB +: 5])
                           || (|s_reg.info[`PC_RSV_LSB +: 2])
                           || (|s_reg.info[`PC_NUM_LSB +: 3]);
        end
        default: begin
          s_next.st = ST_HUNT;
        end
      endcase
    end

    // detect holds through a stopped stream until the gap runs out
    if (gap_expired && !s_next.found) begin
      s_next.detect = 1'b0;
      ev[`IRQ_LOST] = s_reg.detect;
    end

    s_next.unlock_q  = pll_unlock;
    ev[`IRQ_UNLOCK]  = pll_unlock && !s_reg.unlock_q;

    // apb: one wait state, then pready with data; writes land on that edge
    access = psel && penable;
    commit = access && s_reg.pready;
    rd     = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `OFS_STATUS:   rd = status_word(s_reg, pll_unlock);
      `OFS_IRQ_STAT: rd = {27'h0, s_reg.irq_stat};
      `OFS_IRQ_MASK: rd = {27'h0, s_reg.mask};
      `OFS_INFO_B0:  rd = {24'h0, s_reg.info[7:0]};
      `OFS_INFO_B1:  rd = {24'h0, s_reg.info[15:8]};
      `OFS_LEN_B0:   rd = {24'h0, s_reg.len[7:0]};
      `OFS_LEN_B1:   rd = {24'h0, s_reg.len[15:8]};
      default:       rd_err = 1'b1;
    endcase

    if (access && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = rd_err;
      s_next.prdata  = (pwrite || rd_err) ? 32'h0000_0000 : rd;
    end else begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h0000_0000;
    end

    w1c = 5'h00;
    if (commit && pwrite && !s_reg.pslverr) begin
      if (paddr == `OFS_IRQ_STAT) begin
        w1c = pwdata[4:0];
      end
      if (paddr == `OFS_IRQ_MASK) begin
        s_next.mask = pwdata[4:0];
      end
    end
    // a new event beats a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
    // mask bit one hides the source; unlock_irq0_mask is bit IRQ_UNLOCK
    s_next.irq      = |(s_next.irq_stat & ~s_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg      <= '0;
      s_reg.mask <= `IRQ_MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign detect  = s_reg.detect;
  assign irq     = s_reg.irq;
endmodule // burst_detector

// >>> hw/burst_map.svh
// constants for the burst preamble detector and its source end
// assumes inclusion by bare name from any design file
`ifndef BURST_MAP_SVH
`define BURST_MAP_SVH

// sync words and burst-info fields
`define SYNC_PA        16'hf872
`define SYNC_PB        16'h4e1f
`define TYPE_NULL      5'h00
`define TYPE_PAUSE     5'h03
`define PC_TYPE_LSB    0
`define PC_RSV_LSB     5
`define PC_ERR_BIT     7
`define PC_DEP_LSB     8
`define PC_NUM_LSB     13
`define PC_LEGAL_MASK  16'h1f9f

// timing counts, in frames or pclk cycles
`define GAP_FRAMES     4096
`define FRAME_DIV      833

// register byte offsets on apb
`define OFS_STATUS     12'h000
`define OFS_IRQ_STAT   12'h004
`define OFS_IRQ_MASK   12'h008
`define OFS_INFO_B0    12'h010
`define OFS_INFO_B1    12'h014
`define OFS_LEN_B0     12'h018
`define OFS_LEN_B1     12'h01c

// status word field positions
`define ST_DETECT      0
`define ST_UNLOCK      1
`define ST_TYPE_LSB    8
`define ST_NULL        13
`define ST_PAUSE       14
`define ST_RSV_TYPE    15
`define ST_ERR         16
`define ST_RSV_BITS    17
`define ST_DEP_LSB     18
`define ST_NUM_LSB     23

// interrupt bits, shared by status and mask
`define IRQ_FOUND      0
`define IRQ_LOST       1
`define IRQ_ERR        2
`define IRQ_RSV        3
`define IRQ_UNLOCK     4
`define IRQ_MASK_RST   5'h00

`endif

// >>> hw/burst_pkg.sv
// types shared by the burst preamble detector and its source end
// assumes nothing beyond a systemverilog compiler
package burst_pkg;

  typedef enum logic [1:0] {
    ST_HUNT,
    ST_SYNC2,
    ST_INFO,
    ST_LEN
  } hunt_state_t;

  typedef struct packed {
    hunt_state_t st;
    logic [15:0] info;
    logic [15:0] len;
    logic        detect;
    logic        found;
    logic        unlock_q;
    logic [4:0]  irq_stat;
    logic [4:0]  mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dev_state_t;

  typedef struct packed {
    logic [15:0] div;
    logic [2:0]  idx;
    logic [15:0] info;
    logic [15:0] len;
    logic        rep;
    logic [12:0] rep_cnt;
    logic [12:0] period;
    logic        word_valid;
    logic [15:0] word;
    logic        sent;
  } src_state_t;

endpackage

// >>> hw/burst_link_if.sv
// link between the bitstream source and the preamble detector
// one aligned 16-bit word per frame, marked by a one-cycle strobe on pclk
interface burst_link_if;
  logic        word_valid;
  logic [15:0] word;

  modport src (output word_valid, output word);
  modport dev (input word_valid, input word);
endinterface

// >>> hw/frame_gap_timer.sv
// counts frames since the last restart and pulses once when the gap runs out
// assumes frame is a one-cycle strobe synchronous to pclk
`include "burst_map.svh"

module frame_gap_timer #(
  parameter int GAP_FRAMES = `GAP_FRAMES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic restart,
  input  wire logic frame,
  // result
  output logic      expired
);
  import burst_pkg::*;

  localparam int W = $clog2(GAP_FRAMES + 1);
  localparam logic [W-1:0] LAST = W'(GAP_FRAMES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         expired;
  } gap_state_t;

  gap_state_t s_reg;
  gap_state_t s_next;

  always_comb begin
    s_next         = s_reg;
    s_next.expired = 1'b0;
    if (restart) begin
      s_next.cnt = '0;
      s_next.run = 1'b1;
    end else if (s_reg.run && frame) begin
      if (s_reg.cnt == LAST) begin
        s_next.expired = 1'b1;
        s_next.run     = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;
endmodule // frame_gap_timer

// >>> hw/burst_source.sv
// source end: frames the stream and sends burst preambles on request
// assumes the user side holds send_info and send_len while send_req is high
`include "burst_map.svh"

module burst_source #(
  parameter int FRAME_DIV = `FRAME_DIV
) (
  // clock and reset
  input  wire logic    pclk,
  input  wire logic    presetn,
  // user side
  input  wire logic        send_req,
  input  wire logic [15:0] send_info,
  input  wire logic [15:0] send_len,
  input  wire logic        repeat_en,
  output logic             busy,
  output logic             sent,
  // link
  burst_link_if.src        link
);
  import burst_pkg::*;

  localparam logic [15:0] DIV_LAST = 16'(FRAME_DIV - 1);

  src_state_t s_reg;
  src_state_t s_next;
  logic       tick;

  // burst spacing in frames per data type; zero means no automatic repeat
  function automatic logic [12:0] rep_period(input logic [4:0] t);
    case (t)
      5'h00:               rep_period = 13'h1000;
      5'h01:               rep_period = 13'h0600;
      5'h04, 5'h08:        rep_period = 13'h0180;
      5'h05, 5'h06, 5'h09: rep_period = 13'h0480;
      5'h0b, 5'h0e, 5'h1b: rep_period = 13'h0200;
      5'h0c, 5'h0f, 5'h1c: rep_period = 13'h0400;
      5'h0d:               rep_period = 13'h0800;
      default:             rep_period = 13'h0000;
    endcase
  endfunction

  always_comb begin
    s_next            = s_reg;
    s_next.word_valid = 1'b0;
    s_next.sent       = 1'b0;
    tick              = (s_reg.div == DIV_LAST);
    s_next.div        = tick ? 16'h0000 : s_reg.div + 16'h0001;
    s_next.rep        = s_reg.rep & repeat_en;
    if (tick) begin
      s_next.word_valid = 1'b1;
      case (s_reg.idx)
        3'h0:    s_next.word = `SYNC_PA;
        3'h1:    s_next.word = `SYNC_PB;
        3'h2:    s_next.word = s_reg.info;
        3'h3:    s_next.word = s_reg.len;
        default: s_next.word = 16'h0000;
      endcase
      if (s_reg.idx < 3'h4) begin
        s_next.idx = s_reg.idx + 3'h1;
      end
      if (s_reg.idx == 3'h3) begin
        s_next.sent = 1'b1;
      end
      if (s_next.rep) begin
        if (s_reg.rep_cnt == s_reg.period - 13'h0001) begin
          s_next.rep_cnt = 13'h0000;
          s_next.idx     = 3'h0;
        end else begin
          s_next.rep_cnt = s_reg.rep_cnt + 13'h0001;
        end
      end
    end
    if (send_req && !busy) begin
      // reserved bits and stream number are forced to zero on the wire
      s_next.info    = send_info & `PC_LEGAL_MASK;
      s_next.len     = send_len;
      s_next.idx     = 3'h0;
      s_next.rep_cnt = 13'h0000;
      s_next.period  = rep_period(send_info[4:0]);
      s_next.rep     = repeat_en && (rep_period(send_info[4:0]) != 13'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg     <= '0;
      s_reg.idx <= 3'h4;
    end else begin
      s_reg <= s_next;
    end
  end

  // busy is combinational from state flops only; it stays out of the top outputs
  assign busy            = s_reg.rep || (s_reg.idx < 3'h4);
  assign sent            = s_reg.sent;
  assign link.word_valid = s_reg.word_valid;
  assign link.word       = s_reg.word;
endmodule // burst_source

// >>> verif/burst_link_monitor.sv
// checker for the source-to-detector link and the detector's apb answer timing
// assumes one pclk domain; tb instantiates it beside the link it watches
`include "burst_map.svh"

module burst_link_monitor #(
  parameter int GAP_FRAMES = 32
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link
  input wire logic        word_valid,
  input wire logic [15:0] word,
  // detector outputs and apb
  input wire logic        detect,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] since_pb;
  logic [7:0] frames;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // both counters saturate, so an idle link reads as long gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_pb <= 8'hff;
      frames   <= 8'hff;
    end else begin
      since_pb <= (word_valid && word == `SYNC_PB) ? 8'h00
                : since_pb + {7'h00, since_pb != 8'hff};
      frames   <= (word_valid && word == `SYNC_PA) ? 8'h00
                : frames + {7'h00, word_valid && frames != 8'hff};
    end
  end

  sequence s_pa; word_valid && word == `SYNC_PA; endsequence
  sequence s_pb; word_valid && word == `SYNC_PB; endsequence
  sequence s_burst; s_pa ##4 s_pb ##4 word_valid ##4 word_valid; endsequence

  property p_sync_order; s_pa |-> ##4 s_pb; endproperty
  property p_info_clean; s_pb |-> ##4 word_valid && (word & 16'he060) == 16'h0000; endproperty
  property p_capture; s_burst |-> ##[1:3] detect; endproperty
  property p_cause; $rose(detect) |-> since_pb <= 8'd12; endproperty
  property p_hold;
    $fell(detect) |-> frames >= 8'(GAP_FRAMES) && frames <= 8'(GAP_FRAMES + 4);
  endproperty
  property p_gone; frames > 8'(GAP_FRAMES + 4) |-> !detect; endproperty
  property p_strobe; word_valid |=> !word_valid; endproperty
  property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty

  a_sync_order: assert property (p_sync_order) else $error("second sync word missing");
  a_info_clean: assert property (p_info_clean) else $error("info reserved bits sent");
  a_capture: assert property (p_capture) else $error("preamble not detected");
  a_cause: assert property (p_cause) else $error("detect without sync pair");
  a_hold: assert property (p_hold) else $error("detect dropped off the gap count");
  a_gone: assert property (p_gone) else $error("detect held past the gap");
  a_strobe: assert property (p_strobe) else $error("word strobe longer than a cycle");
  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  a_pulse: assert property (p_pulse) else $error("pready held");
endmodule // burst_link_monitor

// >>> verif/tb.sv
// bench: source and detector face each other on link_a; a second detector on
// link_b takes raw words from the bench that break the framing on purpose
// assumes the hw files are compiled first; both detectors share the apb bus
`include "burst_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [15:0] info; logic [31:0] status; } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pll_unlock, err, sel_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_a, prdata_b, rd;
  logic        pready_a, pready_b, pslverr_a, pslverr_b;
  logic        detect_a, detect_b, irq_a, irq_b, send_req, repeat_en, busy, sent;
  logic [15:0] send_info, send_len;
  int          failures = 0, n_tests = 0, cycles = 0, n;
  row_t        rows [14] = '{'{16'h0000, 32'h00002001}, '{16'h0003, 32'h00004301},
    '{16'h0002, 32'h00008201}, '{16'h0087, 32'h00018701}, '{16'h1f0a, 32'h007c8a01},
    '{16'h0110, 32'h00049001}, '{16'h001a, 32'h00009a01}, '{16'h001d, 32'h00009d01},
    '{16'h009f, 32'h00019f01}, '{16'h0201, 32'h00080101}, '{16'h000b, 32'h00000b01},
    '{16'h001c, 32'h00001c01}, '{16'h000f, 32'h00000f01}, '{16'he061, 32'h00000101}};
  logic [15:0] bad [9] = '{16'h4e1f, 16'hf872, 16'h0005, 16'h0010, 16'hf872, 16'h1234,
    16'h4e1f, 16'h0005, 16'h0010};
  logic [15:0] good [5] = '{16'hf872, 16'hf872, 16'h4e1f, 16'he065, 16'h0040};

  burst_link_if link_a ();
  burst_link_if link_b ();
  burst_source #(.FRAME_DIV(4)) burst_source_i (.pclk(pclk), .presetn(presetn),
    .send_req(send_req), .send_info(send_info), .send_len(send_len),
    .repeat_en(repeat_en), .busy(busy), .sent(sent), .link(link_a));
  burst_detector #(.GAP_FRAMES(32)) burst_detector_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_a), .pready(pready_a), .pslverr(pslverr_a), .pll_unlock(pll_unlock),
    .detect(detect_a), .irq(irq_a), .link(link_a));
  burst_detector #(.GAP_FRAMES(32)) burst_detector_b_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_b), .pready(pready_b), .pslverr(pslverr_b), .pll_unlock(pll_unlock),
    .detect(detect_b), .irq(irq_b), .link(link_b));
  burst_link_monitor #(.GAP_FRAMES(32)) burst_link_monitor_i (.pclk(pclk),
    .presetn(presetn), .word_valid(link_a.word_valid), .word(link_a.word),
    .detect(detect_a), .psel(psel), .penable(penable), .pready(pready_a));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while ((sel_b ? pready_b : pready_a) !== 1'b1);
    rd = sel_b ? prdata_b : prdata_a;
    err = sel_b ? pslverr_b : pslverr_a;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic [15:0] i, input logic [15:0] l);
    @(posedge pclk);
    send_req <= 1'b1;
    send_info <= i;
    send_len <= l;
    do @(posedge pclk); while (busy !== 1'b1);
    send_req <= 1'b0;
    do @(negedge pclk); while (sent !== 1'b1);
    repeat (3) @(negedge pclk);
  endtask

  // sent-to-sent spacing in cycles of an auto-repeated burst type
  task automatic spacing(input logic [15:0] i, input int exp_n);
    @(posedge pclk);
    repeat_en <= 1'b1;
    send(i, 16'h0100);
    n = 3;
    do begin
      @(negedge pclk);
      n++;
    end while (sent !== 1'b1 && n < 3000);
    chk(32'(n), 32'(exp_n), "repeat spacing");
    @(posedge pclk);
    repeat_en <= 1'b0;
  endtask

  // a released word line shows the inverse of its last value
  task automatic raw(input logic [15:0] w);
    @(posedge pclk);
    link_b.word_valid <= 1'b1;
    link_b.word <= w;
    @(posedge pclk);
    link_b.word_valid <= 1'b0;
    link_b.word <= ~w;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, pll_unlock, sel_b, send_req, repeat_en} = '0;
    {paddr, pwdata, send_info, send_len} = '0;
    link_b.word_valid = 1'b0;
    link_b.word = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `OFS_STATUS, 32'hffffffff);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h00002000, "status after reset");
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0, "mask after reset");
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    $display("reset test done");
    foreach (rows[k]) begin
      send(rows[k].info, {8'h5a, rows[k].info[7:0]});
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd, rows[k].status, "status fields");
      apb(1'b0, `OFS_INFO_B0, 32'h0);
      chk(rd, {24'h0, rows[k].info[7:0] & 8'h9f}, "info low");
      apb(1'b0, `OFS_INFO_B1, 32'h0);
      chk(rd, {24'h0, 3'h0, rows[k].info[12:8]}, "info high");
      apb(1'b0, `OFS_LEN_B0, 32'h0);
      chk(rd, {24'h0, rows[k].info[7:0]}, "length low");
      apb(1'b0, `OFS_LEN_B1, 32'h0);
      chk(rd, 32'h5a, "length high");
      $display("row %0d done", k);
    end
    @(negedge pclk);
    chk(32'(irq_a), 32'h1, "irq with events");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000000d, "events after rows");
    apb(1'b1, `OFS_IRQ_MASK, 32'h1f);
    @(posedge pclk);
    pll_unlock <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(32'(irq_a), 32'h0, "all masked");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000001d, "unlock event");
    apb(1'b1, `OFS_IRQ_MASK, 32'h0f);
    repeat (3) @(negedge pclk);
    chk(32'(irq_a), 32'h1, "unlock unmasked");
    apb(1'b1, `OFS_IRQ_STAT, 32'h1f);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    @(negedge pclk);
    chk({rd[31:1], irq_a}, 32'h0, "events cleared");
    @(posedge pclk);
    pll_unlock <= 1'b0;
    $display("irq test done");
    spacing(16'h0004, 1536);
    // clear old events so the loss bit below can only come from this stream
    apb(1'b1, `OFS_IRQ_STAT, 32'h1f);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (detect_a !== 1'b0 && n < 2000);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    @(negedge pclk);
    chk({30'h0, rd[1], detect_a}, 32'h2, "stream lost");
    spacing(16'h000b, 2048);
    $display("repeat and loss test done");
    sel_b = 1'b1;
    foreach (bad[k]) raw(bad[k]);
    @(negedge pclk);
    chk(32'(detect_b), 32'h0, "syncs out of order");
    foreach (good[k]) raw(good[k]);
    repeat (3) @(negedge pclk);
    chk(32'(detect_b), 32'h1, "repeated first sync");
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h03820501, "reserved bits decoded");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h00000009, "reserved bits flagged");
    $display("raw link test done");
    wrap_up();
  end
endmodule // tb
